// ### lsg_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module lsg_phy_model
(
  // Clock
  input  wire logic clk,
  // Line levels
  input  wire logic txd,
  input  wire logic short_mode,
  input  wire logic surge,
  output logic      rxd,
  output logic      sense
);
  // ------
  // Bus echo
  // ------
  // A short to battery holds the bus recessive whatever is sent
  always_ff @(posedge clk)
  begin
    rxd <= short_mode | txd;
  end

  // Overcurrent while driving dominant into a short, or on a surge
  assign sense = (short_mode & ~txd) | surge;
endmodule : lsg_phy_model
`default_nettype wire

// ### lsg_pkg.sv
`default_nettype none
package lsg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] CFG_IDX  = 10'h0B4;
  localparam logic [9:0] DEB_IDX  = 10'h0B5;
  localparam logic [9:0] DLY_IDX  = 10'h0B6;
  localparam logic [9:0] STAT_IDX = 10'h0C0;
  localparam logic [9:0] MASK_IDX = 10'h0C1;
  localparam logic [9:0] SSW_IDX  = 10'h0C2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_FAST_BIT  = 0;
  localparam int CFG_GDIS_BIT  = 1;
  localparam int CFG_SEN_BIT   = 2;
  localparam int CFG_CLRSL_BIT = 4;
  localparam int CFG_CLRSH_BIT = 5;
  localparam int IRQ_STUCK_BIT = 2;
  localparam int IRQ_SHORT_BIT = 3;
  localparam int SSW_STUCK_BIT = 2;
  localparam int SSW_SHORT_BIT = 3;
  localparam logic [7:0] IRQ_USED = 8'h0C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DEB_RST = 8'h0F;
  localparam logic [7:0] DLY_RST = 8'h4F;

  // ----------------------------------------------------------------
  // Filter clock: a 4 MHz tick from the 125 MHz system clock
  // ----------------------------------------------------------------
  localparam int SYS_CLK_KHZ  = 125000;
  localparam int FILT_CLK_KHZ = 4000;
  localparam int TICK_GCD     = 1000;
  localparam logic [7:0] TICK_STEP = 8'(FILT_CLK_KHZ / TICK_GCD);
  localparam logic [7:0] TICK_MOD  = 8'(SYS_CLK_KHZ / TICK_GCD);

endpackage : lsg_pkg
`default_nettype wire

// ### lsg_short_filter.sv
`timescale 1ns/10ps
`default_nettype none
module lsg_short_filter
  import lsg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Filter timing
  input  wire logic       tick,
  input  wire logic [7:0] gate_delay,
  input  wire logic [7:0] deb_length,
  // Line levels
  input  wire logic       txd,
  input  wire logic       rxd,
  input  wire logic       sense,
  // Result
  output logic            short_pulse
);

  typedef struct packed {
    logic [7:0] gate_cnt;
    logic [8:0] deb_cnt;
    logic       pulse;
  } lsg_filt_s;

  lsg_filt_s st_reg;
  lsg_filt_s st_next;
  logic      cond;
  logic      gate_open;
  logic      gated;

  // ----------------------------------------------------------------
  // Gate and debounce
  // ----------------------------------------------------------------
  // Gate is combinational so it closes in the same cycle the line moves
  always_comb
  begin
    st_next   = st_reg;
    cond      = ~txd & rxd;                          // [RULE2]
    gate_open = (gate_delay == 8'h00) ||             // [RULE5]
                (cond && st_reg.gate_cnt >= gate_delay); // [RULE3]
    gated     = sense & gate_open;                   // [RULE1]
    if (!cond)
      st_next.gate_cnt = 8'h00;                      // [RULE4]
    else if (tick && st_reg.gate_cnt < gate_delay)
      st_next.gate_cnt = st_reg.gate_cnt + 8'h01;
    st_next.pulse = 1'b0;
    if (!gated)
      st_next.deb_cnt = 9'h000;
    else if (tick && st_reg.deb_cnt <= {1'b0, deb_length})
    begin
      st_next.deb_cnt = st_reg.deb_cnt + 9'h001;
      st_next.pulse   = (st_reg.deb_cnt == {1'b0, deb_length}); // [RULE6]
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign short_pulse = st_reg.pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_gate_zero_open: assert property // [RULE5]
    ((gate_delay == 8'h00) |-> gate_open)
    else $error("gate closed with zero delay");
  a_gate_close_now: assert property // [RULE4]
    ((gate_delay != 8'h00 && !cond) |-> !gate_open)
    else $error("gate open without txd low rxd high");
  a_debounce_run: assert property // [RULE6]
    (short_pulse |-> $past(gated) && $past(tick)
                     && $past(st_reg.deb_cnt) == {1'b0, $past(deb_length)})
    else $error("short declared before debounce count");

endmodule : lsg_short_filter
`default_nettype wire

// ### lsg_short_guard.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// (RULE1) Take overcurrent sense from the PHY
// (RULE2) Nonzero delay: watch TXD and RXD for gating
// (RULE3) Open gate after delay ticks of TXD-low RXD-high
// (RULE4) Close gate at once; count restarts
// (RULE5) Zero delay keeps the gate always open
// (RULE6) Debounce length+1 ticks then set status bit 3
// (RULE7) Status read clears the short status bit
// (RULE8) Guard enabled: short sets latched flag forcing TXD
// (RULE9) Latched flag readable as status word bit 3
// (RULE10) Flag holds until clear-short strobe bit 5
// (RULE11) Strobe bit 4 clears stuck-low flag
// (RULE12) Guard disable overrides all TXD forcing
// (RULE13) Host keeps guard disable zero normally
// (RULE14) Fast slew bit drives slew bypass output
// (RULE15) Config bits 3 and 7:6 read zero
// (RULE16) Debounce length 8-bit RW, resets 0F
// (RULE17) Guard enable resets to zero
// (RULE18) Gate delay 8-bit RW, resets 4F
// (RULE19) PHY TXD is host TXD OR unsuppressed flags
module lsg_short_guard
  import lsg_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Host and PHY lines
  input  wire logic        HOST_TXD,
  input  wire logic        PHY_RXD,
  input  wire logic        OVERCURRENT_SENSE,
  output logic             PHY_TXD,
  output logic             SLEW_BYPASS,
  // Other protection sources
  input  wire logic        STUCK_LOW_EVT,
  input  wire logic        LOW_POWER_FORCE,
  // Interrupt
  output logic             IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  tick_acc;
    logic        tick;
    logic        fast_slew_bypass;
    logic        transmit_guard_disable;
    logic        short_guard_enable;
    logic [7:0]  short_debounce_length;
    logic [7:0]  short_gate_delay;
    logic        short_latched_flag;
    logic        stuck_low_flag;
    logic [7:0]  irq_status;
    logic [7:0]  irq_mask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        txd;
    logic        slew;
    logic        irq;
  } lsg_top_s;

  lsg_top_s st_reg;
  lsg_top_s st_next;

  logic       short_pulse;
  logic [8:0] tick_sum;
  logic       apb_done;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] wbyte;
  logic       force_txd;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Word hit on a register index, aligned accesses only
  function automatic logic hit(input logic [11:0] a,
                               input logic [9:0]  idx);
    hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, CFG_IDX) | hit(a, DEB_IDX) | hit(a, DLY_IDX) |
             hit(a, STAT_IDX) | hit(a, MASK_IDX) | hit(a, SSW_IDX);
  endfunction : mapped

  // Read mux; strobes and unused config bits always read zero
  function automatic logic [31:0] rd_word(input logic [11:0] a,
                                          input lsg_top_s    s);
    logic [7:0] v;
    v = 8'h00; // [RULE15]
    if (hit(a, CFG_IDX))
    begin
      v[CFG_FAST_BIT] = s.fast_slew_bypass;
      v[CFG_GDIS_BIT] = s.transmit_guard_disable;
      v[CFG_SEN_BIT]  = s.short_guard_enable;
    end
    if (hit(a, DEB_IDX))
      v = s.short_debounce_length;
    if (hit(a, DLY_IDX))
      v = s.short_gate_delay;
    if (hit(a, STAT_IDX))
      v = s.irq_status;
    if (hit(a, MASK_IDX))
      v = s.irq_mask;
    if (hit(a, SSW_IDX))
    begin
      v[SSW_SHORT_BIT] = s.short_latched_flag; // [RULE9]
      v[SSW_STUCK_BIT] = s.stuck_low_flag;
    end
    rd_word = {24'h000000, v};
  endfunction : rd_word

  // ----------------------------------------------------------------
  // Gating and debounce filter
  // ----------------------------------------------------------------
  // Gate watches the TXD actually driven toward the PHY
  lsg_short_filter u_filter (
    .clk         (CLK_SYS),
    .rst_n       (RSTN),
    .tick        (st_reg.tick),
    .gate_delay  (st_reg.short_gate_delay),
    .deb_length  (st_reg.short_debounce_length),
    .txd         (st_reg.txd),
    .rxd         (PHY_RXD),
    .sense       (OVERCURRENT_SENSE),
    .short_pulse (short_pulse)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Set always wins over a clear landing in the same cycle
  always_comb
  begin
    st_next  = st_reg;
    // 125/4 is not integral, so a phase accumulator spreads the ticks
    tick_sum = {1'b0, st_reg.tick_acc} + {1'b0, TICK_STEP};
    if (tick_sum >= {1'b0, TICK_MOD})
    begin
      st_next.tick_acc = 8'(tick_sum - {1'b0, TICK_MOD});
      st_next.tick     = 1'b1;
    end
    else
    begin
      st_next.tick_acc = tick_sum[7:0];
      st_next.tick     = 1'b0;
    end

    // APB: two-cycle access phase, answer from registers
    apb_done = PSEL & PENABLE & st_reg.pready;
    wr_done  = apb_done & PWRITE & mapped(PADDR);
    rd_done  = apb_done & ~PWRITE & mapped(PADDR);
    wbyte    = PWDATA[7:0];
    st_next.pready  = PSEL & PENABLE & ~st_reg.pready;
    st_next.pslverr = PSEL & PENABLE & ~st_reg.pready & ~mapped(PADDR);
    st_next.prdata  = 32'h00000000;
    if (PSEL & PENABLE & ~st_reg.pready & ~PWRITE)
      st_next.prdata = rd_word(PADDR, st_reg);

    // Writable fields
    if (wr_done && hit(PADDR, CFG_IDX))
    begin
      st_next.fast_slew_bypass       = wbyte[CFG_FAST_BIT];
      st_next.transmit_guard_disable = wbyte[CFG_GDIS_BIT];
      st_next.short_guard_enable     = wbyte[CFG_SEN_BIT];
      if (wbyte[CFG_CLRSH_BIT])
        st_next.short_latched_flag = 1'b0; // [RULE10]
      if (wbyte[CFG_CLRSL_BIT])
        st_next.stuck_low_flag = 1'b0;     // [RULE11]
    end
    if (wr_done && hit(PADDR, DEB_IDX))
      st_next.short_debounce_length = wbyte; // [RULE16]
    if (wr_done && hit(PADDR, DLY_IDX))
      st_next.short_gate_delay = wbyte;      // [RULE18]
    if (wr_done && hit(PADDR, MASK_IDX))
      st_next.irq_mask = wbyte & IRQ_USED;
    if (wr_done && hit(PADDR, STAT_IDX))
      st_next.irq_status = st_reg.irq_status & ~wbyte;

    // Reading the status register clears it
    if (rd_done && hit(PADDR, STAT_IDX))
      st_next.irq_status = 8'h00; // [RULE7]

    // Events, applied last so they beat any clear
    if (short_pulse)
    begin
      st_next.irq_status[IRQ_SHORT_BIT] = 1'b1; // [RULE6] [RULE17]
      if (st_reg.short_guard_enable)
        st_next.short_latched_flag = 1'b1;      // [RULE8]
    end
    if (STUCK_LOW_EVT)
    begin
      st_next.irq_status[IRQ_STUCK_BIT] = 1'b1;
      st_next.stuck_low_flag            = 1'b1;
    end

    // Output drivers
    force_txd = st_reg.short_latched_flag | st_reg.stuck_low_flag |
                LOW_POWER_FORCE;
    st_next.txd  = HOST_TXD | // [RULE12] [RULE19]
                   (force_txd & ~st_reg.transmit_guard_disable);
    st_next.slew = st_next.fast_slew_bypass; // [RULE14]
    st_next.irq  = |(st_next.irq_status & st_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // TXD resets recessive; guard enable resets off
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      st_reg                       <= '0; // [RULE17]
      st_reg.short_debounce_length <= DEB_RST;
      st_reg.short_gate_delay      <= DLY_RST;
      st_reg.txd                   <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign PRDATA      = st_reg.prdata;
  assign PREADY      = st_reg.pready;
  assign PSLVERR     = st_reg.pslverr;
  assign PHY_TXD     = st_reg.txd;
  assign SLEW_BYPASS = st_reg.slew;
  assign IRQ         = st_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // Config writes carrying a clear strobe; a bare negated sequence
  // cannot stand in an antecedent, so the hold checks use these
  logic clr_short_wr;
  logic clr_stuck_wr;
  assign clr_short_wr = wr_done & hit(PADDR, CFG_IDX) &
                        PWDATA[CFG_CLRSH_BIT];
  assign clr_stuck_wr = wr_done & hit(PADDR, CFG_IDX) &
                        PWDATA[CFG_CLRSL_BIT];

  // Completed read of the status register
  sequence s_stat_read;
    PSEL && PENABLE && PREADY && !PWRITE && hit(PADDR, STAT_IDX);
  endsequence

  // Completed write of the config register with the clear-short strobe
  sequence s_clr_short;
    PSEL && PENABLE && PREADY && PWRITE && hit(PADDR, CFG_IDX)
      && PWDATA[CFG_CLRSH_BIT];
  endsequence

  // Completed write of the config register with the clear-stuck strobe
  sequence s_clr_stuck;
    PSEL && PENABLE && PREADY && PWRITE && hit(PADDR, CFG_IDX)
      && PWDATA[CFG_CLRSL_BIT];
  endsequence

  // Latched flags: set, hold, clear
  a_short_latch_set: assert property // [RULE8]
    ((short_pulse && st_reg.short_guard_enable) |=>
       st_reg.short_latched_flag)
    else $error("short not latched while guard enabled");
  a_short_latch_hold: assert property // [RULE10]
    ((st_reg.short_latched_flag && !clr_short_wr) |=>
       st_reg.short_latched_flag)
    else $error("latched short flag dropped without strobe");
  a_short_clear: assert property // [RULE10]
    ((s_clr_short and !short_pulse) |=>
       !st_reg.short_latched_flag)
    else $error("latched short flag kept after its strobe");
  a_latch_needs_en: assert property // [RULE17]
    ((!st_reg.short_guard_enable && !st_reg.short_latched_flag) |=>
       !st_reg.short_latched_flag)
    else $error("short latched while guard enable is off");
  a_stuck_hold: assert property // [RULE11]
    ((st_reg.stuck_low_flag && !clr_stuck_wr) |=>
       st_reg.stuck_low_flag)
    else $error("stuck-low flag dropped without strobe");
  a_stuck_clear: assert property // [RULE11]
    ((s_clr_stuck and !STUCK_LOW_EVT) |=>
       !st_reg.stuck_low_flag)
    else $error("stuck-low flag kept after its strobe");

  // Status and interrupt
  a_stat_read_clr: assert property // [RULE7]
    ((s_stat_read and !short_pulse) |=>
       !st_reg.irq_status[IRQ_SHORT_BIT])
    else $error("short status survived a status read");
  a_short_status: assert property // [RULE6]
    (short_pulse |=> st_reg.irq_status[IRQ_SHORT_BIT])
    else $error("short status not set on detection");
  a_irq_level: assert property
    (IRQ == |(st_reg.irq_status & st_reg.irq_mask))
    else $error("irq differs from masked status");

  // Line drivers
  a_txd_forced: assert property // [RULE19]
    ((st_reg.short_latched_flag && !st_reg.transmit_guard_disable)
       |=> PHY_TXD)
    else $error("txd not forced by latched short");
  a_lp_forced: assert property // [RULE12]
    ((LOW_POWER_FORCE && !st_reg.transmit_guard_disable) |=> PHY_TXD)
    else $error("txd not forced by low-power request");
  a_guard_off_pass: assert property // [RULE12]
    (st_reg.transmit_guard_disable |=> PHY_TXD == $past(HOST_TXD))
    else $error("txd forced while guard disabled");
  a_slew_follow: assert property // [RULE14]
    (SLEW_BYPASS == st_reg.fast_slew_bypass)
    else $error("slew bypass output differs from config");

  // Register reads and bus answer
  a_cfg_unused_zero: assert property // [RULE15]
    ((PSEL && PENABLE && !PREADY && !PWRITE && hit(PADDR, CFG_IDX))
       |=> PRDATA[7:6] == 2'b00 && !PRDATA[3])
    else $error("unused config bits read nonzero");
  a_ssw_flag: assert property // [RULE9]
    ((PSEL && PENABLE && !PREADY && !PWRITE && hit(PADDR, SSW_IDX))
       |=> PRDATA[SSW_SHORT_BIT] == $past(st_reg.short_latched_flag))
    else $error("status word does not show latched short");
  a_pready_pulse: assert property
    (PREADY |=> !PREADY)
    else $error("pready held over two cycles");
  a_apb_wait: assert property
    ((PSEL && PENABLE && !PREADY) |=> PREADY)
    else $error("no answer one cycle into access phase");
  a_apb_err: assert property
    ((PSEL && PENABLE && !PREADY && !mapped(PADDR)) |=> PSLVERR)
    else $error("unmapped access not flagged");
  a_rd_idle_zero: assert property
    (!PREADY |-> PRDATA == 32'h00000000)
    else $error("read data shown outside answer cycle");

endmodule : lsg_short_guard
`default_nettype wire

// ### lsg_short_guard_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lsg_short_guard_tb;
  import lsg_pkg::*;
  // ------
  // Signals and model state
  // ------
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        host_txd, rxd, sense, phy_txd, slew, stuck_evt, lp_force;
  logic        irq, short_mode, surge, m_fsh, m_fst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  m_cfg, lfsr;
  int          fail_count, checks;

  // Free-running clock, 8 ns
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  lsg_short_guard i_dut
  (
    .CLK_SYS           (clk),
    .RSTN              (rstn),
    .PSEL              (psel),
    .PENABLE           (penable),
    .PWRITE            (pwrite),
    .PADDR             (paddr),
    .PWDATA            (pwdata),
    .PRDATA            (prdata),
    .PREADY            (pready),
    .PSLVERR           (pslverr),
    .HOST_TXD          (host_txd),
    .PHY_RXD           (rxd),
    .OVERCURRENT_SENSE (sense),
    .PHY_TXD           (phy_txd),
    .SLEW_BYPASS       (slew),
    .STUCK_LOW_EVT     (stuck_evt),
    .LOW_POWER_FORCE   (lp_force),
    .IRQ               (irq)
  );

  lsg_phy_model i_phy
  (
    .clk        (clk),
    .txd        (phy_txd),
    .short_mode (short_mode),
    .surge      (surge),
    .rxd        (rxd),
    .sense      (sense)
  );

  // ------
  // Helpers
  // ------
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt

  // Expected TXD level from the bench's own flag model
  function automatic logic exp_txd();
    return host_txd | ((m_fsh | m_fst | lp_force) & ~m_cfg[1]);
  endfunction : exp_txd

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk

  // Bounded wait for PREADY (sel=1) or IRQ (sel=0); overrun ends the run
  task automatic wait_for(input logic sel, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while ((sel ? pready : irq) !== 1'h1 && n < lim);
    if ((sel ? pready : irq) !== 1'h1)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wait_for

  // One APB transfer; the request stands until PREADY is sampled high
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] wd);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'h1;
    wait_for(1'h1, 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
    apb(1'h0, idx, 8'h00);
    chk(rd, {24'h000000, e});
  endtask : rdchk

  // TXD is registered, so let it settle before comparing
  task automatic txdchk();
    repeat (3) @(posedge clk);
    chk(32'(phy_txd), 32'(exp_txd()));
  endtask : txdchk

  // ------
  // Main sequence
  // ------
  initial
  begin
    fail_count = 0;
    checks     = 0;
    rstn       = 1'h0;
    {psel, penable, pwrite, stuck_evt, lp_force, short_mode} = 6'h00;
    surge      = 1'h0;
    host_txd   = 1'h1;
    paddr      = 12'h000;
    pwdata     = 32'h00000000;
    m_cfg      = 8'h00;
    {m_fsh, m_fst} = 2'h0;
    lfsr       = 8'h04;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    chk(32'(irq), 32'h0);
    rdchk(CFG_IDX, 8'h00);
    rdchk(DEB_IDX, 8'h0F);
    rdchk(DLY_IDX, 8'h4F);
    txdchk();
    $display("test reset values done");

    // Random values through both count registers
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      apb(1'h1, DEB_IDX, lfsr);
      rdchk(DEB_IDX, lfsr);
      apb(1'h1, DLY_IDX, ~lfsr);
      rdchk(DLY_IDX, ~lfsr);
    end
    apb(1'h1, CFG_IDX, 8'h37);
    m_cfg = 8'h07;
    rdchk(CFG_IDX, 8'h07);
    chk(32'(slew), 32'h1);
    apb(1'h1, 10'h3FF, 8'hAA);
    chk(32'(err), 32'h1);
    apb(1'h1, CFG_IDX, 8'h00);
    m_cfg = 8'h00;
    repeat (2) @(posedge clk);
    chk(32'(slew), 32'h0);
    $display("test registers done");

    // Open gate; surges of at most three ticks must not count
    apb(1'h1, MASK_IDX, 8'h0C);
    apb(1'h1, DLY_IDX, 8'h00);
    apb(1'h1, DEB_IDX, 8'h03);
    apb(1'h1, CFG_IDX, 8'h04);
    m_cfg = 8'h04;
    repeat (4)
    begin
      surge <= 1'h1;
      repeat (90) @(posedge clk);
      surge <= 1'h0;
      repeat (40) @(posedge clk);
    end
    rdchk(STAT_IDX, 8'h00);
    surge <= 1'h1;
    wait_for(1'h0, 400);
    surge <= 1'h0;
    m_fsh = 1'h1;
    rdchk(STAT_IDX, 8'h08);
    rdchk(STAT_IDX, 8'h00);
    chk(32'(irq), 32'h0);
    rdchk(SSW_IDX, 8'h08);
    host_txd <= 1'h0;
    txdchk();
    apb(1'h1, CFG_IDX, 8'h20);
    m_cfg = 8'h00;
    m_fsh = 1'h0;
    rdchk(SSW_IDX, 8'h00);
    txdchk();
    $display("test debounce and latch done");

    // Gate delay of eight ticks, broken up before it runs out
    apb(1'h1, DLY_IDX, 8'h08);
    apb(1'h1, DEB_IDX, 8'h00);
    short_mode <= 1'h1;
    repeat (4)
    begin
      host_txd <= 1'h0;
      repeat (150) @(posedge clk);
      host_txd <= 1'h1;
      repeat (50) @(posedge clk);
    end
    rdchk(STAT_IDX, 8'h00);
    short_mode <= 1'h0;
    surge      <= 1'h1;
    host_txd   <= 1'h0;
    repeat (400) @(posedge clk);
    surge <= 1'h0;
    rdchk(STAT_IDX, 8'h00);
    short_mode <= 1'h1;
    wait_for(1'h0, 600);
    short_mode <= 1'h0;
    rdchk(STAT_IDX, 8'h08);
    rdchk(SSW_IDX, 8'h00);
    $display("test gate done");

    // Stuck-low flag, masking, guard disable and low-power forcing
    apb(1'h1, MASK_IDX, 8'h00);
    stuck_evt <= 1'h1;
    @(posedge clk);
    stuck_evt <= 1'h0;
    m_fst = 1'h1;
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    rdchk(SSW_IDX, 8'h04);
    txdchk();
    apb(1'h1, CFG_IDX, 8'h02);
    m_cfg = 8'h02;
    lp_force <= 1'h1;
    txdchk();
    apb(1'h1, CFG_IDX, 8'h10);
    m_cfg = 8'h00;
    m_fst = 1'h0;
    rdchk(SSW_IDX, 8'h00);
    txdchk();
    lp_force <= 1'h0;
    txdchk();
    rdchk(STAT_IDX, 8'h04);
    $display("test stuck-low and override done");

    // Unmasked stuck-low event raises IRQ; a one written clears it
    apb(1'h1, MASK_IDX, 8'h04);
    rdchk(MASK_IDX, 8'h04);
    stuck_evt <= 1'h1;
    wait_for(1'h0, 20);
    stuck_evt <= 1'h0;
    m_fst = 1'h1;
    apb(1'h1, STAT_IDX, 8'h04);
    chk(32'(irq), 32'h0);
    rdchk(STAT_IDX, 8'h00);
    txdchk();
    $display("test interrupt clear done");
    tally_and_finish();
  end
endmodule : lsg_short_guard_tb
`default_nettype wire
